// File: shared/hpp_pkg.sv
// Shared constants, modes and helpers of the host parallel port
package hpp_pkg;
  typedef enum logic [2:0] {
    HPP_SRAM,
    HPP_AMUX,
    HPP_SMUX,
    HPP_SFIFO,
    HPP_WAVE,
    HPP_MMC
  } hpp_mode_e;

  typedef enum logic {
    HPP_SM_IDLE,
    HPP_SM_DATA
  } hpp_smux_e;

  typedef enum logic [1:0] {
    HPP_H_IDLE,
    HPP_H_ADDR,
    HPP_H_DATA,
    HPP_H_REL
  } hpp_host_e;

  // Bus shape
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int NCTL = 16;
  localparam int REG_SEL_BIT = 7;
  localparam int REG_IDX_W = 7;
  localparam int NREG = 128;
  localparam int BUF_SEL_W = 5;
  localparam int BASE_SEL_W = 2;
  localparam int PTR_W = 4;
  localparam int BUF_WORDS = 512;
  localparam int BYTE_W = 8;

  // Waveform memory: 8 kB as 16-bit words, 16 words per state
  localparam int WAVE_AW = 12;
  localparam int WAVE_WORDS = 4096;
  localparam int STATE_W = 8;
  localparam int SLOT_W = 4;
  localparam logic [SLOT_W-1:0] WD_OUT = 4'h0;
  localparam logic [SLOT_W-1:0] WD_OE = 4'h1;
  localparam logic [SLOT_W-1:0] WD_CTRL = 4'h2;
  localparam logic [SLOT_W-1:0] WD_ALT = 4'h3;
  localparam int COND_PIN_LSB = 8;
  localparam int COND_PIN_W = 4;
  localparam int COND_LVL_BIT = 12;
  localparam int IRQ_BIT = 13;
  localparam int DATA_BIT = 14;
  localparam int WIDE_BIT = 15;

  // Configuration register indices
  localparam logic [REG_IDX_W-1:0] XFER_IDX = 7'h10;
  localparam logic [REG_IDX_W-1:0] SIZE_IDX = 7'h11;

  // Timing
  localparam int CLK_PS = 50000;
  localparam int ACC_MIN_PS = 32500;
  localparam int ACC_MIN_RAW = (ACC_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int ACC_MIN_CYC = (ACC_MIN_RAW < 1) ? 1 : ACC_MIN_RAW;
  localparam int SYNC_LAT = 2;
  localparam int STROBE_CYC = ACC_MIN_CYC + SYNC_LAT + 3;
  localparam int CNT_W = 4;
  localparam int MMC_IRQ_CYC = 4;

  function automatic logic [8:0] buf_addr(input logic [BUF_SEL_W-1:0] sel,
                                          input logic [PTR_W-1:0] ptr);
    buf_addr = {sel, ptr};
  endfunction : buf_addr
endpackage : hpp_pkg

// File: shared/hpp_if.sv
// Pin bundle between the host and the device end, with wire resolution
`timescale 1ns/10ps
interface hpp_if;
  import hpp_pkg::*;
  logic [AW-1:0] addr;
  logic cs_n;
  logic oe_n;
  logic we_n;
  logic address_valid_n;
  logic [DW-1:0] host_ad_out;
  logic host_ad_oe;
  logic [DW-1:0] dev_ad_out;
  logic dev_ad_oe;
  logic rdy;
  logic int_n;
  logic [NCTL-1:0] host_ctl_out;
  logic [NCTL-1:0] host_ctl_oe;
  logic [NCTL-1:0] dev_ctl_out;
  logic [NCTL-1:0] dev_ctl_oe;
  logic dev_cmd_oe;
  logic host_cmd_oe;
  logic [DW-1:0] ad;
  logic [NCTL-1:0] ctl;
  logic cmd;

  // Undriven lines read as zero; the open-drain command line idles high
  assign ad = dev_ad_oe ? dev_ad_out : (host_ad_oe ? host_ad_out : '0);
  assign ctl = (dev_ctl_oe & dev_ctl_out) | (~dev_ctl_oe & host_ctl_oe & host_ctl_out);
  assign cmd = ~(dev_cmd_oe | host_cmd_oe);

  modport dev (
    input addr, cs_n, oe_n, we_n, address_valid_n, ad, ctl, cmd,
    output dev_ad_out, dev_ad_oe, rdy, int_n, dev_ctl_out, dev_ctl_oe, dev_cmd_oe
  );
  modport host (
    output addr, cs_n, oe_n, we_n, address_valid_n, host_ad_out, host_ad_oe,
    output host_ctl_out, host_ctl_oe, host_cmd_oe,
    input ad, rdy, int_n, ctl, cmd
  );
endinterface : hpp_if

// File: core/hpp_device.sv
// Device end of the host parallel port: strobe decode, registers, buffers, waveform engine
`timescale 1ns/10ps
// What this block does
// - Top address bit picks registers or buffers, except in slave FIFO mode (always buffers)
// - Low seven address bits index a register
// - Buffer access uses transfer buffer and size
// - Single and burst accesses via async strobes
// - Next word on OE rise or A0 toggle
// - Access cycle of minimum length is completed
// - Host may pin top address bit high/low
// - Multiplexed port shares one 16-bit bus
// - Host asserts chip select and OE to read
// - Writes use CS and WE; OE ignored
// - Write data taken at first WE/CS rise
// - Address valid low in address, high data
// - Synchronous multiplexed port on shared bus
// - Ready marks read data and write acknowledge
// - Slave FIFO reaches four buffers, optionally all
// - Engine: 256 states, 8/16 bit, 16 pins
// - Engine steps on inputs, drives outputs
// - Engine descriptor in its own 8 kB memory
// - Engine may drive the interrupt output
// - MMC mode signals events on command line
module hpp_device import hpp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link to the host
  hpp_if.dev link,
  // Configuration
  input wire hpp_mode_e mode,
  input wire logic fifo_ext,
  input wire logic mmc_int_en,
  // Events toward the host
  input wire logic irq_req,
  input wire logic mmc_event,
  // Waveform descriptor load
  input wire logic wave_load,
  input wire logic [WAVE_AW-1:0] wave_addr,
  input wire logic [DW-1:0] wave_data,
  // Status
  output logic wr_seen,
  output logic [DW-1:0] last_wr_data,
  output logic [STATE_W-1:0] wave_state
);
  localparam int SYNC_W = 4 + AW + DW + NCTL;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic prev_cs_n;
  logic prev_rd_act;
  logic prev_wr_act;
  logic prev_adv_n;
  logic prev_a0;
  logic [DW-1:0] prev_ad;
  logic [AW-1:0] lat_addr;
  logic [AW-1:0] sm_addr;
  logic sm_wr;
  hpp_smux_e sm_st;
  logic [PTR_W-1:0] ptr;
  logic [BUF_SEL_W-1:0] prev_sel;
  logic [DW-1:0] cfg [NREG];
  logic [DW-1:0] bufm [BUF_WORDS];
  logic [DW-1:0] wmem [WAVE_WORDS];
  logic [CNT_W-1:0] cmd_cnt;

  // Synchronised pins (first stage feeds only the second)
  wire logic s_cs_n = sync2[SYNC_W-1];
  wire logic s_oe_n = sync2[SYNC_W-2];
  wire logic s_we_n = sync2[SYNC_W-3];
  wire logic s_adv_n = sync2[SYNC_W-4];
  wire logic [AW-1:0] s_addr = sync2[DW+NCTL +: AW];
  wire logic [DW-1:0] s_ad = sync2[NCTL +: DW];
  wire logic [NCTL-1:0] s_ctl = sync2[NCTL-1:0];

  // Mode decode
  wire logic m_smux = (mode == HPP_SMUX);
  wire logic m_fifo = (mode == HPP_SFIFO);
  wire logic m_wave = (mode == HPP_WAVE);
  wire logic m_async = (mode == HPP_SRAM) || (mode == HPP_AMUX) || m_fifo;

  // Async strobe decode; OE is a don't-care while WE is low
  wire logic rd_act = m_async & !s_cs_n & !s_oe_n & s_we_n;
  wire logic wr_act = m_async & !s_cs_n & !s_we_n;
  wire logic rd_end = prev_rd_act & !rd_act;
  wire logic wr_end = prev_wr_act & !wr_act;
  wire logic adv_rise = (mode == HPP_AMUX) & !prev_adv_n & s_adv_n & !s_cs_n;
  wire logic a0_tog = (mode == HPP_SRAM) & rd_act & prev_rd_act & (s_addr[0] != prev_a0);

  // Synchronous multiplexed phases straight from same-clock pins
  wire logic sm_addr_ph = m_smux & !link.cs_n & !link.address_valid_n;
  wire logic sm_go = m_smux & (sm_st == HPP_SM_DATA) & !link.cs_n & link.address_valid_n;
  wire logic sm_wr_go = sm_go & sm_wr & !link.we_n;
  wire logic sm_rd_go = sm_go & !sm_wr;

  // Address and space selection
  // Bypass the latch in the cycle it loads, so the first read word already uses the new address
  wire logic [AW-1:0] amux_addr = adv_rise ? prev_ad[AW-1:0] : lat_addr;
  wire logic [AW-1:0] eff_addr = m_smux ? sm_addr : ((mode == HPP_AMUX) ? amux_addr : s_addr);
  wire logic reg_sp = !m_fifo & eff_addr[REG_SEL_BIT];
  wire logic [REG_IDX_W-1:0] reg_idx = eff_addr[REG_IDX_W-1:0];
  wire logic [BUF_SEL_W-1:0] fifo_sel = fifo_ext ? s_addr[BUF_SEL_W-1:0] :
                                        {{(BUF_SEL_W-BASE_SEL_W){1'b0}}, s_addr[BASE_SEL_W-1:0]};
  wire logic [BUF_SEL_W-1:0] dma_sel = cfg[XFER_IDX][BUF_SEL_W-1:0];
  wire logic [BUF_SEL_W-1:0] buf_sel = m_fifo ? fifo_sel : dma_sel;
  wire logic [PTR_W-1:0] size_last = cfg[SIZE_IDX][PTR_W-1:0] - 1'b1;

  // Waveform descriptor fetch for the current state
  wire logic [DW-1:0] w_out = wmem[{wave_state, WD_OUT}];
  wire logic [DW-1:0] w_oe = wmem[{wave_state, WD_OE}];
  wire logic [DW-1:0] w_ctrl = wmem[{wave_state, WD_CTRL}];
  wire logic [DW-1:0] w_alt = wmem[{wave_state, WD_ALT}];
  wire logic w_cond = s_ctl[w_ctrl[COND_PIN_LSB +: COND_PIN_W]] == w_ctrl[COND_LVL_BIT];
  wire logic [STATE_W-1:0] w_next = w_cond ? w_ctrl[STATE_W-1:0] : w_alt[STATE_W-1:0];
  wire logic w_drive = m_wave & w_ctrl[DATA_BIT];

  // Unified access strobes
  wire logic wr_go = (m_async & wr_end) | sm_wr_go;
  wire logic [DW-1:0] wdat = m_smux ? link.ad : prev_ad;
  wire logic reg_wr = wr_go & reg_sp;
  wire logic buf_wr = wr_go & !reg_sp;
  wire logic [DW-1:0] buf_word = bufm[buf_addr(buf_sel, ptr)];
  wire logic [DW-1:0] rd_data = reg_sp ? cfg[reg_idx] : buf_word;
  wire logic ptr_step = (!reg_sp & (buf_wr | ((rd_end | a0_tog) & m_async) | sm_rd_go)) | w_drive;
  wire logic [PTR_W-1:0] next_ptr = (ptr == size_last) ? '0 : ptr + 1'b1;
  wire logic [DW-1:0] wave_word = w_ctrl[WIDE_BIT] ? buf_word :
                                  {{(DW-BYTE_W){1'b0}}, buf_word[BYTE_W-1:0]};
  wire logic [DW-1:0] next_ad_out = w_drive ? wave_word : rd_data;
  wire logic next_ad_oe = rd_act | sm_rd_go | w_drive;
  wire logic irq_pin = irq_req & ((mode != HPP_MMC) | mmc_int_en);
  wire logic next_int = (m_wave & w_ctrl[IRQ_BIT]) | irq_pin;

  // Strobes and buses pass two flops before the async decode; the synchronous multiplexed phases use the raw pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {link.cs_n, link.oe_n, link.we_n, link.address_valid_n,
                link.addr, link.ad, link.ctl};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_cs_n <= 1'b1;
      prev_rd_act <= 1'b0;
      prev_wr_act <= 1'b0;
      prev_adv_n <= 1'b1;
      prev_a0 <= 1'b0;
      prev_ad <= '0;
    end else begin
      prev_cs_n <= s_cs_n;
      prev_rd_act <= rd_act;
      prev_wr_act <= wr_act;
      prev_adv_n <= s_adv_n;
      prev_a0 <= s_addr[0];
      prev_ad <= s_ad;
    end
  end

  // Address phase of the async multiplexed bus: low byte of AD is the address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lat_addr <= '0;
    end else if (adv_rise) begin
      lat_addr <= prev_ad[AW-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sm_st <= HPP_SM_IDLE;
      sm_addr <= '0;
      sm_wr <= 1'b0;
    end else begin
      unique case (sm_st)
        HPP_SM_IDLE: begin
          if (sm_addr_ph) begin
            sm_addr <= link.ad[AW-1:0];
            sm_wr <= !link.we_n;
            sm_st <= HPP_SM_DATA;
          end
        end
        HPP_SM_DATA: begin
          if (sm_rd_go || sm_wr_go || !m_smux) begin
            sm_st <= HPP_SM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++) begin
        cfg[i] <= '0;
      end
    end else if (reg_wr) begin
      cfg[reg_idx] <= wdat;
    end
  end

  // Buffer and descriptor storage carry no reset
  always_ff @(posedge clk) begin
    if (buf_wr) begin
      bufm[buf_addr(buf_sel, ptr)] <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (wave_load) begin
      wmem[wave_addr] <= wave_data;
    end
  end

  // Burst pointer restarts whenever another buffer is chosen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= '0;
      prev_sel <= '0;
    end else begin
      prev_sel <= buf_sel;
      if (buf_sel != prev_sel) begin
        ptr <= '0;
      end else if (ptr_step) begin
        ptr <= next_ptr;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wave_state <= '0;
    end else begin
      wave_state <= m_wave ? w_next : '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_cnt <= '0;
    end else if (mode == HPP_MMC && mmc_event) begin
      cmd_cnt <= CNT_W'(MMC_IRQ_CYC);
    end else if (cmd_cnt != '0) begin
      cmd_cnt <= cmd_cnt - 1'b1;
    end
  end

  // All pin outputs are registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.dev_ad_out <= '0;
      link.dev_ad_oe <= 1'b0;
      link.rdy <= 1'b0;
      link.int_n <= 1'b1;
      link.dev_ctl_out <= '0;
      link.dev_ctl_oe <= '0;
      link.dev_cmd_oe <= 1'b0;
      wr_seen <= 1'b0;
      last_wr_data <= '0;
    end else begin
      link.dev_ad_out <= next_ad_out;
      link.dev_ad_oe <= next_ad_oe;
      link.rdy <= sm_rd_go | sm_wr_go;
      link.int_n <= !next_int;
      link.dev_ctl_out <= m_wave ? w_out : '0;
      link.dev_ctl_oe <= m_wave ? w_oe : '0;
      link.dev_cmd_oe <= (cmd_cnt != '0);
      wr_seen <= wr_go;
      if (wr_go) begin
        last_wr_data <= wdat;
      end
    end
  end
endmodule : hpp_device

// File: core/hpp_host.sv
// Host end of the host parallel port: drives strobes for one access at a time
`timescale 1ns/10ps
module hpp_host import hpp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link to the device
  hpp_if.host link,
  // Command
  input wire hpp_mode_e mode,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic [DW-1:0] rdata,
  // Control pins and events
  input wire logic [NCTL-1:0] ctl_drive,
  input wire logic [NCTL-1:0] ctl_enable,
  output logic irq_seen,
  output logic event_seen
);
  hpp_host_e st;
  logic [CNT_W-1:0] cnt;
  logic wr;
  logic [DW-1:0] wd;
  logic [DW-1:0] ad_s1;
  logic [DW-1:0] ad_s2;
  logic [1:0] int_s;
  logic [1:0] cmd_s;
  logic cmd_prev;

  wire logic m_smux = (mode == HPP_SMUX);
  wire logic m_amux = (mode == HPP_AMUX);
  wire logic cnt_zero = (cnt == '0);
  wire logic [CNT_W-1:0] strobe_len = CNT_W'(STROBE_CYC - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ad_s1 <= '0;
      ad_s2 <= '0;
      int_s <= 2'h3;
      cmd_s <= 2'h3;
      cmd_prev <= 1'b1;
      irq_seen <= 1'b0;
      event_seen <= 1'b0;
      link.host_ctl_out <= '0;
      link.host_ctl_oe <= '0;
      link.host_cmd_oe <= 1'b0;
    end else begin
      ad_s1 <= link.ad;
      ad_s2 <= ad_s1;
      int_s <= {int_s[0], link.int_n};
      cmd_s <= {cmd_s[0], link.cmd};
      cmd_prev <= cmd_s[1];
      irq_seen <= !int_s[1];
      event_seen <= cmd_prev & !cmd_s[1];
      link.host_ctl_out <= ctl_drive;
      link.host_ctl_oe <= ctl_enable;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= HPP_H_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      wd <= '0;
      cmd_ready <= 1'b1;
      done <= 1'b0;
      rdata <= '0;
      link.addr <= '0;
      link.cs_n <= 1'b1;
      link.oe_n <= 1'b1;
      link.we_n <= 1'b1;
      link.address_valid_n <= 1'b1;
      link.host_ad_out <= '0;
      link.host_ad_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st)
        HPP_H_IDLE: begin
          if (cmd_valid && (mode != HPP_WAVE) && (mode != HPP_MMC)) begin
            cmd_ready <= 1'b0;
            wr <= cmd_write;
            wd <= cmd_wdata;
            link.cs_n <= 1'b0;
            cnt <= strobe_len;
            if (m_amux || m_smux) begin
              link.address_valid_n <= 1'b0;
              link.host_ad_out <= {{(DW-AW){1'b0}}, cmd_addr};
              link.host_ad_oe <= 1'b1;
              link.we_n <= !(m_smux & cmd_write);
              if (m_smux) begin
                cnt <= '0;
              end
              st <= HPP_H_ADDR;
            end else begin
              link.addr <= cmd_addr;
              link.host_ad_out <= cmd_wdata;
              link.host_ad_oe <= cmd_write;
              link.we_n <= !cmd_write;
              link.oe_n <= cmd_write;
              st <= HPP_H_DATA;
            end
          end
        end
        HPP_H_ADDR: begin
          if (cnt_zero) begin
            link.address_valid_n <= 1'b1;
            link.host_ad_out <= wd;
            link.host_ad_oe <= wr;
            link.we_n <= !wr;
            link.oe_n <= wr | m_smux;
            cnt <= strobe_len;
            st <= HPP_H_DATA;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        HPP_H_DATA: begin
          if (m_smux ? link.rdy : cnt_zero) begin
            if (!wr) begin
              rdata <= m_smux ? link.ad : ad_s2;
            end
            link.cs_n <= 1'b1;
            link.we_n <= 1'b1;
            link.oe_n <= 1'b1;
            cnt <= strobe_len;
            st <= HPP_H_REL;
          end else if (!cnt_zero) begin
            cnt <= cnt - 1'b1;
          end
        end
        HPP_H_REL: begin
          // Write data is held past the strobe so the device's sampled copy stays valid
          if (cnt_zero) begin
            link.host_ad_oe <= 1'b0;
            done <= 1'b1;
            cmd_ready <= 1'b1;
            st <= HPP_H_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end
endmodule : hpp_host

// File: verification/hpp_checker.sv
// Concurrent checks on the pins between the host end and the device end
`timescale 1ns/10ps
module hpp_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host strobes and drive enable
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic address_valid_n,
  input wire logic host_ad_oe,
  // Device answers
  input wire logic dev_ad_oe,
  input wire logic rdy,
  input wire logic cmd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_rdy_pulse: assert property (rdy |=> !rdy)
    else $error("ready held longer than one cycle");
  chk_rdy_cause: assert property (rdy |-> $past(!cs_n && address_valid_n) &&
      $past(!cs_n && !address_valid_n, 2))
    else $error("ready without address then data phase");
  chk_rdy_data: assert property (rdy |-> dev_ad_oe == we_n)
    else $error("ready read data not driven or write driven");
  chk_bus_single: assert property (!(dev_ad_oe && host_ad_oe))
    else $error("both ends drive the shared bus");
  // Four cycles covers the synchroniser and the drive register
  chk_read_drive: assert property ((!cs_n && !oe_n && we_n && address_valid_n)[*4]
      |-> dev_ad_oe)
    else $error("read strobes held but device not driving");
  chk_idle_quiet: assert property (cs_n [*4] |-> !dev_ad_oe)
    else $error("device drives bus while deselected");
  chk_write_quiet: assert property ((!we_n)[*2] |-> !dev_ad_oe)
    else $error("device drives bus during a write");
  chk_cmd_pulse: assert property ($fell(cmd) |-> (!cmd)[*4] ##1 cmd)
    else $error("command line event pulse not four cycles");

  cover property (rdy && we_n);
  cover property (rdy && !we_n);
  cover property ($rose(dev_ad_oe));
  cover property ($fell(cmd));
endmodule : hpp_checker

// File: verification/host_parallel_port_tb.sv
// Bench joining host and device ends and checking transfers end to end
`timescale 1ns/10ps
module host_parallel_port_tb import hpp_pkg::*;;
  logic clk;
  logic rstn;
  hpp_mode_e mode;
  logic fifo_ext, mmc_int_en, irq_req, mmc_event, wave_load;
  logic [WAVE_AW-1:0] wave_addr;
  logic [DW-1:0] wave_data, cmd_wdata, rdata, last_wr_data, q;
  logic cmd_valid, cmd_write, cmd_ready, done, wr_seen, irq_seen, event_seen;
  logic [AW-1:0] cmd_addr;
  logic [NCTL-1:0] ctl_drive, ctl_enable;
  logic [STATE_W-1:0] wave_state;
  int err_count, n_checks, wr_cnt, ev_cnt;

  hpp_if link ();
  hpp_device hpp_device_inst (.clk(clk), .rstn(rstn), .link(link.dev), .mode(mode),
    .fifo_ext(fifo_ext), .mmc_int_en(mmc_int_en), .irq_req(irq_req), .mmc_event(mmc_event),
    .wave_load(wave_load), .wave_addr(wave_addr), .wave_data(wave_data), .wr_seen(wr_seen),
    .last_wr_data(last_wr_data), .wave_state(wave_state));
  hpp_host hpp_host_inst (.clk(clk), .rstn(rstn), .link(link.host), .mode(mode),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .done(done), .rdata(rdata), .ctl_drive(ctl_drive),
    .ctl_enable(ctl_enable), .irq_seen(irq_seen), .event_seen(event_seen));
  hpp_checker hpp_checker_inst (.clk(clk), .rstn(rstn), .cs_n(link.cs_n), .oe_n(link.oe_n),
    .we_n(link.we_n), .address_valid_n(link.address_valid_n), .host_ad_oe(link.host_ad_oe),
    .dev_ad_oe(link.dev_ad_oe), .rdy(link.rdy), .cmd(link.cmd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr_seen === 1'b1) wr_cnt++;
    if (event_seen === 1'b1) ev_cnt++;
  end

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // One host access; waits on done with a bound so a lost answer cannot hang the run
  task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("access done", 16'h0001, {15'h0000, done});
    chk("ready after done", 16'h0001, {15'h0000, cmd_ready});
    q = rdata;
  endtask : xfer

  task automatic t_regs;
    hpp_mode_e ms [3] = '{HPP_SRAM, HPP_AMUX, HPP_SMUX};
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    for (int i = 0; i < 3; i++) begin
      mode = ms[i];
      a = {1'b1, 7'(i * 63)};
      d = 16'hA5C3 ^ 16'(i);
      xfer(1'b1, a, d);
      chk("last write", d, last_wr_data);
      xfer(1'b1, a ^ 8'h01, ~d);
      xfer(1'b0, a, 16'h0000);
      chk("register read", d, q);
    end
  endtask : t_regs

  task automatic t_buf;
    int w;
    mode = HPP_SRAM;
    xfer(1'b1, {1'b1, XFER_IDX}, 16'h0003);
    xfer(1'b1, {1'b1, SIZE_IDX}, 16'h0002);
    w = wr_cnt;
    xfer(1'b1, 8'h00, 16'h1111);
    xfer(1'b1, 8'h00, 16'h2222);
    chk("write pulses", 16'h0002, 16'(wr_cnt - w));
    xfer(1'b0, 8'h00, 16'h0000);
    chk("buffer word 0", 16'h1111, q);
    xfer(1'b0, 8'h00, 16'h0000);
    chk("buffer word 1", 16'h2222, q);
    xfer(1'b0, 8'h00, 16'h0000);
    chk("buffer wrap", 16'h1111, q);
    xfer(1'b0, 8'h80, 16'h0000);
    chk("register kept", 16'hA5C3, q);
  endtask : t_buf

  task automatic t_fifo;
    logic [AW-1:0] a;
    mode = HPP_SFIFO;
    // Top bit set on the first pass on purpose: this mode always reaches buffers
    for (int i = 0; i < 2; i++) begin
      fifo_ext = i[0];
      a = i[0] ? 8'h1D : 8'h81;
      xfer(1'b1, a, 16'h3C00 | 16'(i));
      xfer(1'b1, a, 16'hC300);
      xfer(1'b0, a, 16'h0000);
      chk("fifo word", 16'h3C00 | 16'(i), q);
    end
    fifo_ext = 1'b0;
  endtask : t_fifo

  task automatic t_irq;
    int e;
    mode = HPP_SRAM;
    irq_req = 1'b1;
    repeat (6) @(negedge clk);
    chk("int_n set", 16'h0000, 16'(link.int_n));
    chk("irq seen", 16'h0001, 16'(irq_seen));
    irq_req = 1'b0;
    repeat (6) @(negedge clk);
    chk("int_n clear", 16'h0001, 16'(link.int_n));
    mode = HPP_MMC;
    irq_req = 1'b1;
    repeat (6) @(negedge clk);
    chk("int_n unused", 16'h0001, 16'(link.int_n));
    mmc_int_en = 1'b1;
    repeat (6) @(negedge clk);
    chk("int_n optional", 16'h0000, 16'(link.int_n));
    irq_req = 1'b0;
    mmc_int_en = 1'b0;
    e = ev_cnt;
    mmc_event = 1'b1;
    @(negedge clk);
    mmc_event = 1'b0;
    repeat (10) @(negedge clk);
    chk("event seen", 16'h0001, 16'(ev_cnt > e));
    chk("cmd idle", 16'h0001, 16'(link.cmd));
  endtask : t_irq

  task automatic t_wave;
    logic [27:0] tbl [8] = '{{12'h000, 16'h00A5}, {12'h001, 16'hFFFF}, {12'h002, 16'h0001},
      {12'h003, 16'h0001}, {12'h010, 16'h5A00}, {12'h011, 16'hFFFF}, {12'h012, 16'h2000},
      {12'h013, 16'h2000}};
    logic [3:0] seen;
    mode = HPP_SRAM;
    ctl_drive = 16'h1234;
    ctl_enable = 16'hFFFF;
    repeat (3) @(negedge clk);
    chk("host control pins", 16'h1234, link.ctl);
    ctl_enable = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      wave_load = 1'b1;
      {wave_addr, wave_data} = tbl[i];
    end
    @(negedge clk);
    wave_load = 1'b0;
    mode = HPP_WAVE;
    seen = 4'h0;
    repeat (12) begin
      @(negedge clk);
      if (wave_state === 8'h01) seen[0] = 1'b1;
      if (link.ctl === 16'h00A5) seen[1] = 1'b1;
      if (link.ctl === 16'h5A00) seen[2] = 1'b1;
      if (link.int_n === 1'b0) seen[3] = 1'b1;
    end
    chk("engine states and pins", 16'h0007, 16'(seen[2:0]));
    chk("engine interrupt", 16'h0001, 16'(seen[3]));
    mode = HPP_SRAM;
    repeat (4) @(negedge clk);
    chk("engine idle state", 16'h0000, 16'(wave_state));
  endtask : t_wave

  initial begin
    rstn = 1'b0;
    mode = HPP_SRAM;
    {fifo_ext, mmc_int_en, irq_req, mmc_event, wave_load} = 5'h00;
    {wave_addr, wave_data, cmd_wdata, cmd_addr} = '0;
    {cmd_valid, cmd_write, ctl_drive, ctl_enable} = '0;
    {err_count, n_checks, wr_cnt, ev_cnt} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_regs();
    $display("register test done");
    t_buf();
    $display("buffer test done");
    t_fifo();
    $display("fifo test done");
    t_irq();
    $display("event test done");
    t_wave();
    $display("engine test done");
    wrap_up();
  end

  // Whole run is well under 2000 cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule : host_parallel_port_tb
